/* File: verilog/shadow_map_regs.vh */
`ifndef SHADOW_MAP_REGS_VH
`define SHADOW_MAP_REGS_VH

// System coprocessor address of the three registers
`define MAP_REG_NUM 5'h06
`define SEL_SETS_7_TO_9 3'h3
`define SEL_SETS_10_TO_12 3'h4
`define SEL_SETS_13_TO_15 3'h5

// Field layout
`define FLD_W 10
`define FLD_LO_LSB 0
`define FLD_MID_LSB 10
`define FLD_HI_LSB 20
`define RSVD_BIT 30
`define MFLAG_BIT 31
`define FIELDS_W 30
`define DATA_W 32

// Field encodings
`define FIELD_INVALID 10'h3FF
`define FIELD_RESET 10'h3FE

// Configuration of this core
`define NUM_VP 2
`define VP_W 1
`define NUM_THREAD 8
`define THREAD_W 3
`define NUM_UPPER 9
`define SS_W 4
`define FIRST_UPPER_SET 4'h7
`define LOWER_TOP_SET 4'h6

// Field kinds
`define KIND_NONE 2'b00
`define KIND_FIXED 2'b01
`define KIND_PROG 2'b10
// Kinds of sets 15 down to 7, two bits each; set 7 in the low bits
`define KIND_VEC 18'h01AAA
// Hard-wired values start above the thread-context count
`define HARD_MAP_BASE 10'h020

`endif

/* File: verilog/shadow_map_field.v */
`timescale 1ns/100ps
`include "shadow_map_regs.vh"

module shadow_map_field #(
  parameter [1:0] KIND = `KIND_PROG,
  parameter [9:0] FIXED_VAL = `HARD_MAP_BASE
) (
  input wire mclk,
  input wire reset_n,
  input wire ce,
  input wire wr_en,
  input wire [9:0] wr_val,
  output wire [9:0] value,
  output wire valid
);

  reg [9:0] value_r;

  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      value_r <= `FIELD_RESET;
    else if (ce && wr_en && KIND == `KIND_PROG)
      value_r <= wr_val;
  end

  assign value = (KIND == `KIND_PROG) ? value_r :
                 (KIND == `KIND_FIXED) ? FIXED_VAL : `FIELD_INVALID;
  assign valid = (value < `FIELD_RESET);

endmodule

/* File: verilog/shadow_map_highest.v */
`timescale 1ns/100ps
`include "shadow_map_regs.vh"

module shadow_map_highest (
  input wire [8:0] upper_valid,
  input wire [3:0] lower_highest,
  output reg [3:0] highest
);

  integer i;
  reg run;

  // count valid sets from set 7 up
  always @*
  begin
    highest = lower_highest;
    run = (lower_highest == `LOWER_TOP_SET);
    for (i = 0; i < `NUM_UPPER; i = i + 1)
    begin
      if (run && upper_valid[i])
        highest = highest + 4'h1;
      else
        run = 1'b0;
    end
  end

endmodule

/* File: verilog/shadow_set_map_regs_upper.v */
`timescale 1ns/100ps
`include "shadow_map_regs.vh"

module shadow_set_map_regs_upper (
  input wire mclk,
  input wire reset_n,
  input wire ce,
  input wire [4:0] sc_reg_num,
  input wire [2:0] sc_reg_sel,
  input wire sc_wr_en,
  input wire sc_rd_en,
  input wire [31:0] sc_wdata,
  input wire [0:0] sc_vp,
  input wire [7:0] thread_vp_bind,
  input wire [7:0] lower_highest,
  input wire [0:0] steer_vp,
  input wire [3:0] current_shadow_select,
  output reg [31:0] sc_rdata_r,
  output reg [9:0] steer_map_r,
  output reg steer_valid_r,
  output reg [7:0] highest_shadow_select_r
);

  localparam NF = `NUM_VP * `NUM_UPPER;
  // absent sets only from the top down
  localparam [17:0] KINDS = `KIND_VEC;
  localparam [1:0] IDX_LO = 2'h0;
  localparam [1:0] IDX_MID = 2'h1;
  localparam [1:0] IDX_HI = 2'h2;
  localparam [1:0] IDX_NONE = 2'h3;

  wire [NF*`FLD_W-1:0] fields;
  wire [NF-1:0] valids;
  wire [`NUM_VP*`SS_W-1:0] highest_nxt;
  wire [`NUM_VP*`FIELDS_W-1:0] word_lo;
  wire [`NUM_VP*`FIELDS_W-1:0] word_mid;
  wire [`NUM_VP*`FIELDS_W-1:0] word_hi;

  // Register decode
  // Exact select compares keep the lower mapping words out
  wire num_hit;
  wire hit_lo;
  wire hit_mid;
  wire hit_hi;
  wire addr_hit;
  wire [2:0] reg_hit;
  reg [1:0] reg_idx;
  assign num_hit = (sc_reg_num == `MAP_REG_NUM);
  assign hit_lo = num_hit && (sc_reg_sel == `SEL_SETS_7_TO_9);
  assign hit_mid = num_hit && (sc_reg_sel == `SEL_SETS_10_TO_12);
  assign hit_hi = num_hit && (sc_reg_sel == `SEL_SETS_13_TO_15);
  assign addr_hit = hit_lo || hit_mid || hit_hi;
  assign reg_hit = {hit_hi, hit_mid, hit_lo};

  always @*
  begin
    reg_idx = IDX_NONE;
    if (hit_lo)
      reg_idx = IDX_LO;
    else if (hit_mid)
      reg_idx = IDX_MID;
    else if (hit_hi)
      reg_idx = IDX_HI;
  end

  // Presence of next register derived from the field kinds
  wire [2:0] present;
  wire flag_2;
  wire flag_3;
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1)
    begin : g_pres
      assign present[k] = (KINDS[6*k+1:6*k] != `KIND_NONE) &&
                          (KINDS[6*k+3:6*k+2] != `KIND_NONE) &&
                          (KINDS[6*k+5:6*k+4] != `KIND_NONE);
    end
  endgenerate
  assign flag_2 = present[0];
  assign flag_3 = present[1] & flag_2;

  // thread context bound to writer
  // A whole word is refused, so no field half-lands
  // Values past the thread count are stored as written
  wire [2:0] field_ok;
  genvar t;
  generate
    for (t = 0; t < 3; t = t + 1)
    begin : g_chk
      wire [`FLD_W-1:0] wv;
      wire [`THREAD_W-1:0] thr;
      wire names_thread;
      assign wv = sc_wdata[t*`FLD_W +: `FLD_W];
      assign thr = wv[`THREAD_W-1:0];
      assign names_thread = (wv < `NUM_THREAD);
      assign field_ok[t] = !names_thread ||
                           (thread_vp_bind[thr] == sc_vp[0]);
    end
  endgenerate

  // Refused or foreign writes leave every field untouched
  wire wr_any;
  assign wr_any = sc_wr_en && addr_hit && (&field_ok);

  // one field set per virtual processor
  genvar v;
  genvar g;
  generate
    for (v = 0; v < `NUM_VP; v = v + 1)
    begin : g_vp
      wire wr_here;
      assign wr_here = wr_any && (sc_vp == v);
      for (g = 0; g < `NUM_UPPER; g = g + 1)
      begin : g_set
        localparam [9:0] SET_OFS = g;
        // field position g mod 3
        // Hard-wired and absent fields drop writes inside
        shadow_map_field #(
          .KIND(KINDS[2*g+1:2*g]),
          .FIXED_VAL(`HARD_MAP_BASE + SET_OFS)
        ) u_field (
          .mclk(mclk),
          .reset_n(reset_n),
          .ce(ce),
          .wr_en(wr_here && reg_hit[g/3]),
          .wr_val(sc_wdata[(g%3)*`FLD_W +: `FLD_W]),
          .value(fields[(v*`NUM_UPPER+g)*`FLD_W +: `FLD_W]),
          .valid(valids[v*`NUM_UPPER+g])
        );
      end
      // highest select per processor: lower sets, plus the unbroken run of valid sets from set 7 when the lower sets reach set 6
      shadow_map_highest u_high (
        .upper_valid(valids[v*`NUM_UPPER +: `NUM_UPPER]),
        .lower_highest(lower_highest[v*`SS_W +: `SS_W]),
        .highest(highest_nxt[v*`SS_W +: `SS_W])
      );
    end
  endgenerate

  // Words as software sees them, per virtual processor
  genvar w;
  generate
    for (w = 0; w < `NUM_VP; w = w + 1)
    begin : g_word
      assign word_lo[w*`FIELDS_W +: `FIELDS_W] =
        fields[w*`NUM_UPPER*`FLD_W +: `FIELDS_W];
      assign word_mid[w*`FIELDS_W +: `FIELDS_W] =
        fields[(w*`NUM_UPPER*`FLD_W)+`FIELDS_W +: `FIELDS_W];
      assign word_hi[w*`FIELDS_W +: `FIELDS_W] =
        fields[(w*`NUM_UPPER*`FLD_W)+2*`FIELDS_W +: `FIELDS_W];
    end
  endgenerate

  // Read composition
  reg [`FIELDS_W-1:0] rd_fields;
  reg rd_flag;
  reg [31:0] rd_nxt;
  integer rbase;
  always @*
  begin
    rbase = sc_vp * `FIELDS_W;
    rd_fields = {`FIELDS_W{1'b0}};
    rd_flag = 1'b0;
    rd_nxt = 32'h00000000;
    case (reg_idx)
      IDX_LO:
      begin
        rd_fields = word_lo[rbase +: `FIELDS_W];
        rd_flag = flag_2;
      end
      IDX_MID:
      begin
        rd_fields = word_mid[rbase +: `FIELDS_W];
        rd_flag = flag_3;
      end
      IDX_HI:
      begin
        rd_fields = word_hi[rbase +: `FIELDS_W];
        rd_flag = 1'b0;
      end
      default:
      begin
        rd_fields = {`FIELDS_W{1'b0}};
        rd_flag = 1'b0;
      end
    endcase
    // Unmapped selects read as zero
    if (addr_hit)
    begin
      rd_nxt[`FIELDS_W-1:0] = rd_fields;
      rd_nxt[`RSVD_BIT] = 1'b0;
      rd_nxt[`MFLAG_BIT] = rd_flag;
    end
  end

  // Steering lookup for the current shadow select
  reg [`NUM_UPPER*`FLD_W-1:0] st_fields;
  reg [`NUM_UPPER-1:0] st_valids;
  reg [9:0] st_nxt;
  reg st_val_nxt;
  always @*
  begin
    st_fields = fields[steer_vp*`NUM_UPPER*`FLD_W +: `NUM_UPPER*`FLD_W];
    st_valids = valids[steer_vp*`NUM_UPPER +: `NUM_UPPER];
    st_nxt = `FIELD_INVALID;
    st_val_nxt = 1'b0;
    // selects below set 7 are not ours
    case (current_shadow_select)
      4'h7:
      begin
        st_nxt = st_fields[0*`FLD_W +: `FLD_W];
        st_val_nxt = st_valids[0];
      end
      4'h8:
      begin
        st_nxt = st_fields[1*`FLD_W +: `FLD_W];
        st_val_nxt = st_valids[1];
      end
      4'h9:
      begin
        st_nxt = st_fields[2*`FLD_W +: `FLD_W];
        st_val_nxt = st_valids[2];
      end
      4'hA:
      begin
        st_nxt = st_fields[3*`FLD_W +: `FLD_W];
        st_val_nxt = st_valids[3];
      end
      4'hB:
      begin
        st_nxt = st_fields[4*`FLD_W +: `FLD_W];
        st_val_nxt = st_valids[4];
      end
      4'hC:
      begin
        st_nxt = st_fields[5*`FLD_W +: `FLD_W];
        st_val_nxt = st_valids[5];
      end
      4'hD:
      begin
        st_nxt = st_fields[6*`FLD_W +: `FLD_W];
        st_val_nxt = st_valids[6];
      end
      4'hE:
      begin
        st_nxt = st_fields[7*`FLD_W +: `FLD_W];
        st_val_nxt = st_valids[7];
      end
      4'hF:
      begin
        st_nxt = st_fields[8*`FLD_W +: `FLD_W];
        st_val_nxt = st_valids[8];
      end
      default:
      begin
        st_nxt = `FIELD_INVALID;
        st_val_nxt = 1'b0;
      end
    endcase
  end

  // Read data holds until the next read
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      sc_rdata_r <= 32'h00000000;
    else if (ce && sc_rd_en)
      sc_rdata_r <= rd_nxt;
  end

  // Reset shows no mapping until the first enabled edge
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      steer_map_r <= `FIELD_INVALID;
    else if (ce)
      steer_map_r <= st_nxt;
  end

  // valid only below the two invalid codes
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      steer_valid_r <= 1'b0;
    else if (ce)
      steer_valid_r <= st_val_nxt;
  end

  // highest select follows fields
  // One edge of lag after a field or lower value change
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      highest_shadow_select_r <= 8'h00;
    else if (ce)
      highest_shadow_select_r <= highest_nxt;
  end

endmodule

/* File: bench/shadow_map_monitor.sv */
`timescale 1ns/100ps
module shadow_map_monitor (
  input wire mclk,
  input wire reset_n,
  input wire ce,
  input wire [4:0] sc_reg_num,
  input wire [2:0] sc_reg_sel,
  input wire sc_rd_en,
  input wire [7:0] lower_highest,
  input wire [3:0] current_shadow_select,
  input wire [31:0] sc_rdata_r,
  input wire [9:0] steer_map_r,
  input wire steer_valid_r,
  input wire [7:0] highest_shadow_select_r
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  sequence rd_s(s);
    ce && sc_rd_en && sc_reg_num == 5'h06 && sc_reg_sel == s;
  endsequence
  AST_FLAG_SETS_7_9:
    assert property (rd_s(3'h3) |=> sc_rdata_r[31])
    else $error("next flag clear in sets 7-9 word");
  AST_FLAG_SETS_10_12:
    assert property (rd_s(3'h4) |=> sc_rdata_r[31])
    else $error("next flag clear in sets 10-12 word");
  AST_TOP_WORD:
    assert property (rd_s(3'h5) |=> sc_rdata_r == 32'h3FFFFC26)
    else $error("sets 13-15 word wrong");
  AST_RSVD_ZERO:
    assert property (sc_rdata_r[30] == 1'b0)
    else $error("reserved bit set");
  AST_VALID_CODE:
    assert property (steer_valid_r == (steer_map_r < 10'h3FE))
    else $error("valid flag disagrees with field");
  AST_LOW_SELECT:
    assert property (ce && current_shadow_select < 4'h7 |=>
      steer_map_r == 10'h3FF)
    else $error("low select not all ones");
  AST_FIXED_SET:
    assert property (ce && current_shadow_select == 4'hD |=>
      steer_map_r == 10'h026 && steer_valid_r)
    else $error("fixed set value wrong");
  AST_HIGHEST_LOW:
    assert property (ce && lower_highest[3:0] < 4'h6 |=>
      highest_shadow_select_r[3:0] == $past(lower_highest[3:0]))
    else $error("highest ignores lower sets");
endmodule
bind shadow_set_map_regs_upper shadow_map_monitor u_shadow_map_monitor (
  .mclk, .reset_n, .ce, .sc_reg_num, .sc_reg_sel, .sc_rd_en,
  .lower_highest, .current_shadow_select, .sc_rdata_r, .steer_map_r,
  .steer_valid_r, .highest_shadow_select_r);

/* File: bench/testbench.sv */
`timescale 1ns/100ps
module testbench;
  logic mclk, reset_n, ce, sc_wr_en, sc_rd_en;
  logic [4:0] sc_reg_num;
  logic [2:0] sc_reg_sel;
  logic [31:0] sc_wdata;
  logic [0:0] sc_vp, steer_vp;
  logic [7:0] thread_vp_bind, lower_highest;
  logic [3:0] current_shadow_select;
  wire [31:0] sc_rdata_r;
  wire [9:0] steer_map_r;
  wire steer_valid_r;
  wire [7:0] highest_shadow_select_r;
  int err_count, compares, i;
  shadow_set_map_regs_upper u_shadow_set_map_regs_upper (
    .mclk, .reset_n, .ce, .sc_reg_num, .sc_reg_sel, .sc_wr_en,
    .sc_rd_en, .sc_wdata, .sc_vp, .thread_vp_bind, .lower_highest,
    .steer_vp, .current_shadow_select, .sc_rdata_r, .steer_map_r,
    .steer_valid_r, .highest_shadow_select_r);
  task report_and_stop;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task acc(input w, input [0:0] v, input [2:0] s, input [31:0] d);
    @(posedge mclk);
    sc_wr_en <= w;
    sc_rd_en <= !w;
    sc_vp <= v;
    sc_reg_sel <= s;
    sc_wdata <= d;
    @(posedge mclk);
    sc_wr_en <= 1'b0;
    sc_rd_en <= 1'b0;
    #1;
  endtask
  task rd(input [0:0] v, input [2:0] s, input [31:0] exp);
    acc(1'b0, v, s, 32'h0);
    chk(sc_rdata_r, exp);
  endtask
  task st(input [0:0] v, input [3:0] s, input [9:0] m);
    @(posedge mclk);
    steer_vp <= v;
    current_shadow_select <= s;
    @(posedge mclk);
    #1;
    chk({steer_valid_r, steer_map_r}, {m < 10'h3FE, m});
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    #100000;
    err_count++;
    report_and_stop;
  end
  initial
  begin
    {reset_n, sc_wr_en, sc_rd_en, sc_wdata, sc_vp, steer_vp} = '0;
    {sc_reg_sel, current_shadow_select} = '0;
    ce = 1'b1;
    sc_reg_num = 5'h06;
    // Threads 0-3 on vp 0, 4-7 on vp 1
    thread_vp_bind = 8'hF0;
    lower_highest = 8'h66;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    for (i = 0; i < 2; i++)
    begin
      rd(i[0], 3'h3, 32'hBFEFFBFE);
      rd(i[0], 3'h4, 32'hBFEFFBFE);
      rd(i[0], 3'h5, 32'h3FFFFC26);
    end
    chk({24'h0, highest_shadow_select_r}, 32'h66);
    // Flag and reserved bit written wrongly on purpose
    acc(1'b1, 1'b0, 3'h3, {2'b01, 10'h3FE, 10'h001, 10'h000});
    rd(1'b0, 3'h3, 32'hBFE00400);
    rd(1'b1, 3'h3, 32'hBFEFFBFE);
    // Enable low, then a foreign register number: neither may store
    @(posedge mclk);
    ce <= 1'b0;
    acc(1'b1, 1'b0, 3'h3, 32'h00000C03);
    @(posedge mclk);
    ce <= 1'b1;
    sc_reg_num <= 5'h07;
    acc(1'b1, 1'b0, 3'h3, 32'h00000C03);
    @(posedge mclk);
    sc_reg_num <= 5'h06;
    rd(1'b0, 3'h3, 32'hBFE00400);
    acc(1'b1, 1'b0, 3'h4, 32'h00000005);
    rd(1'b0, 3'h4, 32'hBFEFFBFE);
    acc(1'b1, 1'b0, 3'h5, 32'h00000000);
    rd(1'b0, 3'h5, 32'h3FFFFC26);
    rd(1'b0, 3'h6, 32'h0);
    chk({24'h0, highest_shadow_select_r}, 32'h68);
    st(1'b0, 4'h8, 10'h001);
    st(1'b1, 4'h8, 10'h3FE);
    st(1'b0, 4'hD, 10'h026);
    st(1'b0, 4'hE, 10'h3FF);
    st(1'b0, 4'h3, 10'h3FF);
    @(posedge mclk);
    lower_highest <= 8'h64;
    @(posedge mclk);
    #1;
    chk({24'h0, highest_shadow_select_r}, 32'h64);
    report_and_stop;
  end
endmodule
